// file: iacr_config_regs.sv
// Function
// RL1: Interface type bit 0 selects the four-wire interface and takes over two pins; 1 two-wire.
// RL2: The high-speed bit keeps the two-wire interface in high-speed mode with no master code.
// RL3: The fast-mode-plus bit lets the two-wire interface use fast mode plus timing.
// RL4: With the timeout bit set and the two-wire interface selected, a serial clock held low over 35 ms resets the two-wire logic.
// RL5: The interrupt driver is push-pull when its type bit is 0 and open drain when it is 1.
// RL6: The interrupt output asserts low when its polarity bit is 0 and high when it is 1.
// RL7: The lockout disable bit turns off the I/O-rail undervoltage lockout and its comparator.
// RL8: A set power-good hold bit keeps that rail's power-good at its old value during transitions.
// RL9: Each rail has a two-bit over-current mask field, rail B in bits 4:3 and rail A in 2:1.
// RL10: A mask field of 00 lets over-current events through at all times.
// RL11: Nonzero mask fields block events during a transition plus 2, 10 or 50 us after it.
// RL12: With the reload bit set and pin zero an input, that pin triggers an OTP reload.
// RL13: Pull bits enable pull-downs on input pins and non-open-drain bidirectional pins, and pull-ups on open-drain bidirectional pins.
// RL14: The extra masking is timed by a counter started when the transition ends.
`timescale 1ns/1ps
`include "iacr_params.svh"
`default_nettype none
module iacr_config_regs
    import iacr_pkg::*;
#(
    parameter int TIMEOUT_CYC = (`IACR_CLK_HZ / 1000) * `IACR_TIMEOUT_MS
)(
    input  wire logic        clk,                  // System clock, 50 MHz.
    input  wire logic        rst,                  // Asynchronous reset, active high.
    input  wire logic        reg_wr,               // Register write strobe.
    input  wire logic [8:0]  reg_addr,             // Register address.
    input  wire logic [7:0]  reg_wdata,            // Write data.
    output logic      [7:0]  reg_rdata,            // Read data, registered.
    output logic             four_wire_sel,        // Four-wire interface selected.
    output logic             pin_takeover,         // Bidir pin three and input pin four taken.
    output logic             two_wire_high_speed_en, // Continuous high-speed mode.
    output logic             two_wire_fast_plus_en,  // Fast mode plus timing.
    output logic             interface_supply_sel, // Two-wire interface supply select.
    output logic             input_supply_sel,     // Input pin supply select.
    input  wire logic        serial_clk_pin,       // Two-wire serial clock from pin.
    output logic             two_wire_reset,       // One-cycle reset pulse to two-wire logic.
    input  wire logic        irq_request,          // Internal interrupt request, active high.
    output logic             interrupt_out_o,      // Interrupt pin output value.
    output logic             interrupt_out_oe,     // Interrupt pin output enable.
    output logic             io_lockout_disable,   // Disables I/O-rail lockout and comparator.
    output logic             io_lockout_cmp_en,    // Lockout comparator enable.
    input  wire logic [1:0]  rail_transition,      // Voltage transition active, [1]=B, [0]=A.
    input  wire logic [1:0]  rail_good_raw,        // Raw power-good per rail.
    output logic      [1:0]  rail_good,            // Power-good after hold.
    input  wire logic [1:0]  rail_oc_hit,          // Raw over-current hit per rail.
    output logic      [1:0]  rail_oc_event,        // Over-current event after masking.
    input  wire logic        input_pin_zero,       // Input pin zero level.
    input  wire logic        pin_zero_is_input,    // Pin zero configured as input.
    output logic             otp_reload_req,       // One-cycle OTP reload request.
    input  wire logic        bidir_two_is_od,      // Bidir pin two is open-drain output.
    input  wire logic        bidir_three_is_od,    // Bidir pin three is open-drain output.
    output logic      [4:1]  pull_down_en,         // Pull-down enable per pin 1..4.
    output logic      [3:2]  pull_up_en            // Pull-up enable for bidir pins 2 and 3.
);
    localparam int EXT1_CYC = `IACR_CLK_HZ / 1000000 * `IACR_EXT1_US;
    localparam int EXT2_CYC = `IACR_CLK_HZ / 1000000 * `IACR_EXT2_US;
    localparam int EXT3_CYC = `IACR_CLK_HZ / 1000000 * `IACR_EXT3_US;
    localparam int TOW = $clog2(TIMEOUT_CYC + 1);

    iacr_byte_t ifopt_reg, ifopt_next, toirq_reg, toirq_next;
    iacr_byte_t rail_reg, rail_next, pull_reg, pull_next;
    iacr_byte_t rdata_next;

    always_comb
    begin
        ifopt_next = ifopt_reg;
        toirq_next = toirq_reg;
        rail_next  = rail_reg;
        pull_next  = pull_reg;
        rdata_next = 8'h00;
        if (reg_wr)
        begin
            unique case (reg_addr)
                `IACR_OFF_IFOPT: ifopt_next = reg_wdata & `IACR_MASK_IFOPT;
                `IACR_OFF_TOIRQ: toirq_next = reg_wdata & `IACR_MASK_TOIRQ;
                `IACR_OFF_RAIL:  rail_next  = reg_wdata & `IACR_MASK_RAIL;
                `IACR_OFF_PULL:  pull_next  = reg_wdata & `IACR_MASK_PULL;
                default:         ;
            endcase
        end
        unique case (reg_addr)
            `IACR_OFF_IFOPT: rdata_next = ifopt_reg;
            `IACR_OFF_TOIRQ: rdata_next = toirq_reg;
            `IACR_OFF_RAIL:  rdata_next = rail_reg;
            `IACR_OFF_PULL:  rdata_next = pull_reg;
            default:         rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ifopt_reg <= `IACR_RST_IFOPT;
            toirq_reg <= `IACR_RST_TOIRQ;
            rail_reg  <= `IACR_RST_RAIL;
            pull_reg  <= `IACR_RST_PULL;
            reg_rdata <= 8'h00;
        end
        else
        begin
            ifopt_reg <= ifopt_next;
            toirq_reg <= toirq_next;
            rail_reg  <= rail_next;
            pull_reg  <= pull_next;
            reg_rdata <= rdata_next;
        end
    end

    assign four_wire_sel          = ~ifopt_reg[`IACR_BIT_IFTYPE]; // RL1
    assign pin_takeover           = ~ifopt_reg[`IACR_BIT_IFTYPE]; // RL1
    assign two_wire_high_speed_en = ifopt_reg[`IACR_BIT_IFTYPE] & ifopt_reg[`IACR_BIT_HSM]; // RL2
    assign two_wire_fast_plus_en  = ifopt_reg[`IACR_BIT_IFTYPE] & ifopt_reg[`IACR_BIT_FMP]; // RL3
    assign interface_supply_sel   = ifopt_reg[`IACR_BIT_IFSUP];
    assign input_supply_sel       = toirq_reg[`IACR_BIT_INSUP];
    assign io_lockout_disable     = rail_reg[`IACR_BIT_UVLODIS]; // RL7
    assign io_lockout_cmp_en      = ~rail_reg[`IACR_BIT_UVLODIS]; // RL7

    // Serial clock and pin zero pass three stages; a level counts when stages two and three agree.
    logic [2:0] scl_sync, pin0_sync;
    logic       scl_low_reg, scl_low_next, pin0_reg, pin0_next;
    logic [TOW-1:0] to_cnt_reg, to_cnt_next;
    logic       tw_rst_next, reload_next;

    always_comb
    begin
        scl_low_next = scl_low_reg;
        pin0_next    = pin0_reg;
        if (scl_sync[1] == scl_sync[2])
            scl_low_next = ~scl_sync[2];
        if (pin0_sync[1] == pin0_sync[2])
            pin0_next = pin0_sync[2];
        to_cnt_next = '0;
        tw_rst_next = 1'b0;
        if (toirq_reg[`IACR_BIT_TOEN] && ifopt_reg[`IACR_BIT_IFTYPE] && scl_low_reg) // RL4
        begin
            if (to_cnt_reg >= TOW'(TIMEOUT_CYC))
                tw_rst_next = 1'b1; // RL4
            else
                to_cnt_next = to_cnt_reg + TOW'(1);
        end
        reload_next = rail_reg[`IACR_BIT_RELOAD] & pin_zero_is_input
                      & pin0_next & ~pin0_reg; // RL12
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            scl_sync       <= 3'h7;
            pin0_sync      <= 3'h0;
            scl_low_reg    <= 1'b0;
            pin0_reg       <= 1'b0;
            to_cnt_reg     <= '0;
            two_wire_reset <= 1'b0;
            otp_reload_req <= 1'b0;
        end
        else
        begin
            scl_sync       <= {scl_sync[1:0], serial_clk_pin};
            pin0_sync      <= {pin0_sync[1:0], input_pin_zero};
            scl_low_reg    <= scl_low_next;
            pin0_reg       <= pin0_next;
            to_cnt_reg     <= to_cnt_next;
            two_wire_reset <= tw_rst_next;
            otp_reload_req <= reload_next;
        end
    end

    // Interrupt pin drive: open drain drives the pin only while the output level is low, active or not.
    logic irq_level;
    always_comb
    begin
        irq_level = irq_request ~^ toirq_reg[`IACR_BIT_IRQHI]; // RL6
    end
    assign interrupt_out_o  = irq_level; // RL6
    assign interrupt_out_oe = ~toirq_reg[`IACR_BIT_IRQOD] | ~irq_level; // RL5

    // Per-rail power-good hold and over-current masking with post-transition extension.
    localparam int EW = $clog2(EXT3_CYC + 1);
    genvar r;
    generate
        for (r = 0; r < 2; r++)
        begin : g_rail
            iacr_ocmask_t mask;
            logic         hold;
            logic [EW-1:0] ext_reg, ext_next, ext_load;
            logic          trans_d_reg;
            logic          good_reg, good_next, oc_next;
            assign mask = (r == 1) ? rail_reg[`IACR_BIT_OCB+1:`IACR_BIT_OCB]
                                   : rail_reg[`IACR_BIT_OCA+1:`IACR_BIT_OCA]; // RL9
            assign hold = (r == 1) ? rail_reg[`IACR_BIT_PGB] : rail_reg[`IACR_BIT_PGA];
            always_comb
            begin
                unique case (mask)
                    2'b01:   ext_load = EW'(EXT1_CYC); // RL11
                    2'b10:   ext_load = EW'(EXT2_CYC); // RL11
                    2'b11:   ext_load = EW'(EXT3_CYC); // RL11
                    default: ext_load = '0;
                endcase
                ext_next = '0;
                if (mask != 2'b00)
                begin
                    if (trans_d_reg && !rail_transition[r])
                        ext_next = ext_load; // RL14
                    else if (ext_reg != '0)
                        ext_next = ext_reg - EW'(1); // RL14
                end
                good_next = (hold && rail_transition[r]) ? good_reg : rail_good_raw[r]; // RL8
                oc_next   = rail_oc_hit[r];
                if (mask != 2'b00 && (rail_transition[r] || trans_d_reg || ext_reg != '0)) // RL10
                    oc_next = 1'b0; // RL11
            end
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    ext_reg          <= '0;
                    trans_d_reg      <= 1'b0;
                    good_reg         <= 1'b0;
                    rail_oc_event[r] <= 1'b0;
                end
                else
                begin
                    ext_reg          <= ext_next;
                    trans_d_reg      <= rail_transition[r];
                    good_reg         <= good_next;
                    rail_oc_event[r] <= oc_next;
                end
            end
            assign rail_good[r] = good_reg;
        end
    endgenerate

    always_comb
    begin
        pull_down_en[1] = pull_reg[1]; // RL13
        pull_down_en[2] = pull_reg[2] & ~bidir_two_is_od;
        pull_down_en[3] = pull_reg[3] & ~bidir_three_is_od;
        pull_down_en[4] = pull_reg[4];
        pull_up_en[2]   = pull_reg[2] & bidir_two_is_od; // RL13
        pull_up_en[3]   = pull_reg[3] & bidir_three_is_od;
    end

    oc_zero_pass_a: assert property (@(posedge clk) disable iff (rst) // RL10
        rail_reg[2:1] == 2'b00 ##1 rail_reg[2:1] == 2'b00 |-> rail_oc_event[0] == $past(rail_oc_hit[0]))
        else $error("rail A over-current dropped with mask zero");
    oc_trans_block_a: assert property (@(posedge clk) disable iff (rst) // RL11
        rail_reg[4:3] != 2'b00 && rail_transition[1] |=> !rail_oc_event[1])
        else $error("rail B over-current passed during transition");
    oc_ext_two_a: assert property (@(posedge clk) disable iff (rst) // RL14
        rail_reg[2:1] == 2'b01 && $fell(rail_transition[0]) && rail_transition == 2'b00
        ##0 (rail_reg[2:1] == 2'b01 && !rail_transition[0])[*1]
        |=> g_rail[0].ext_reg == 100)
        else $error("rail A extension not loaded with 2 us");
    good_hold_a: assert property (@(posedge clk) disable iff (rst) // RL8
        rail_reg[6] && rail_transition[1] |=> rail_good[1] == $past(rail_good[1]))
        else $error("rail B power-good changed while held");
    irq_polarity_a: assert property (@(posedge clk) disable iff (rst) // RL6
        interrupt_out_o == (irq_request ^ ~toirq_reg[0]))
        else $error("interrupt level wrong for polarity");
    irq_od_float_a: assert property (@(posedge clk) disable iff (rst) // RL5
        toirq_reg[1] && interrupt_out_o |-> !interrupt_out_oe)
        else $error("open-drain interrupt drives high");
    four_wire_a: assert property (@(posedge clk) disable iff (rst) // RL1
        four_wire_sel |-> pin_takeover && !two_wire_high_speed_en && !two_wire_fast_plus_en)
        else $error("four-wire mode inconsistent");
    timeout_off_a: assert property (@(posedge clk) disable iff (rst) // RL4
        !toirq_reg[4] |=> !two_wire_reset)
        else $error("two-wire reset while timeout disabled");
    lockout_a: assert property (@(posedge clk) disable iff (rst) // RL7
        io_lockout_disable != io_lockout_cmp_en)
        else $error("lockout comparator enable wrong");
    reload_a: assert property (@(posedge clk) disable iff (rst) // RL12
        otp_reload_req |-> $past(rail_reg[0]) && $past(pin_zero_is_input))
        else $error("reload without enable");
    pull_od_a: assert property (@(posedge clk) disable iff (rst) // RL13
        bidir_three_is_od |-> !pull_down_en[3] && pull_up_en[3] == pull_reg[3])
        else $error("bidir three pull wrong");
    hs_a: assert property (@(posedge clk) disable iff (rst) // RL2
        ifopt_reg[7] && ifopt_reg[6] |-> two_wire_high_speed_en)
        else $error("high-speed not enabled");
    fmp_a: assert property (@(posedge clk) disable iff (rst) // RL3
        ifopt_reg[7] && ifopt_reg[5] |-> two_wire_fast_plus_en)
        else $error("fast mode plus not enabled");
    mask_field_a: assert property (@(posedge clk) disable iff (rst) // RL9
        g_rail[1].mask == rail_reg[4:3] && g_rail[0].mask == rail_reg[2:1])
        else $error("mask field misplaced");
    oc_tail_block_a: assert property (@(posedge clk) disable iff (rst) // RL11
        rail_reg[2:1] != 2'b00 && $fell(rail_transition[0]) |=> !rail_oc_event[0])
        else $error("rail A over-current passed as transition ended");
    oc_ext_fifty_a: assert property (@(posedge clk) disable iff (rst) // RL14
        rail_reg[4:3] == 2'b11 && $fell(rail_transition[1]) |=> g_rail[1].ext_reg == EXT3_CYC)
        else $error("rail B extension not loaded with 50 us");
    four_wire_quiet_a: assert property (@(posedge clk) disable iff (rst) // RL4
        !ifopt_reg[`IACR_BIT_IFTYPE] |=> !two_wire_reset)
        else $error("two-wire reset in four-wire mode");
    reload_pulse_a: assert property (@(posedge clk) disable iff (rst) // RL12
        otp_reload_req |=> !otp_reload_req)
        else $error("reload request longer than one cycle");
endmodule // iacr_config_regs
`default_nettype wire

// file: iacr_params.svh
`ifndef IACR_PARAMS_SVH
`define IACR_PARAMS_SVH
`define IACR_OFF_IFOPT      9'h106
`define IACR_OFF_TOIRQ      9'h143
`define IACR_OFF_RAIL       9'h144
`define IACR_OFF_PULL       9'h145
`define IACR_BIT_IFTYPE     7
`define IACR_BIT_HSM        6
`define IACR_BIT_FMP        5
`define IACR_BIT_IFSUP      4
`define IACR_BIT_TOEN       4
`define IACR_BIT_INSUP      3
`define IACR_BIT_IRQOD      1
`define IACR_BIT_IRQHI      0
`define IACR_BIT_UVLODIS    7
`define IACR_BIT_PGB        6
`define IACR_BIT_PGA        5
`define IACR_BIT_OCB        3
`define IACR_BIT_OCA        1
`define IACR_BIT_RELOAD     0
`define IACR_RST_IFOPT      8'h80
`define IACR_RST_TOIRQ      8'h00
`define IACR_RST_RAIL       8'h00
`define IACR_RST_PULL       8'h00
`define IACR_MASK_IFOPT     8'hF0
`define IACR_MASK_TOIRQ     8'h1B
`define IACR_MASK_RAIL      8'hFF
`define IACR_MASK_PULL      8'h1F
`define IACR_CLK_HZ         50000000
`define IACR_TIMEOUT_MS     35
`define IACR_EXT1_US        2
`define IACR_EXT2_US        10
`define IACR_EXT3_US        50
`endif

// file: iacr_pkg.sv
`default_nettype none
package iacr_pkg;
    typedef logic [7:0] iacr_byte_t;
    typedef logic [1:0] iacr_ocmask_t;
endpackage
`default_nettype wire

// file: iacr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module iacr_host_model (
    input  wire logic       clk,       // System clock.
    output logic            reg_wr,    // Write strobe.
    output logic      [8:0] reg_addr,  // Register address.
    output logic      [7:0] reg_wdata, // Write data.
    input  wire logic [7:0] reg_rdata  // Registered read data.
);
    initial
    begin
        reg_wr = 1'b0;
        reg_addr = 9'h000;
        reg_wdata = 8'h00;
    end

    // Once the strobe drops, the data lines show the inverse so stale data is never reused.
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        repeat (2) @(posedge clk);
        #1;
        d = reg_rdata;
    endtask
endmodule // iacr_host_model
`default_nettype wire

// file: test_interface_app_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_interface_app_config_regs;
    import iacr_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       wr, scl = 1'b1, irq = 1'b0, pz = 1'b0, pzi = 1'b0, od2 = 1'b0, od3 = 1'b0;
    logic [8:0] addr;
    logic [7:0] wd, rdata, d, lf = 8'h56;
    logic [1:0] tr = 2'b00, gr = 2'b00, hit = 2'b00, good, oce;
    logic       fw, pt, hs, fp, isup, gsup, twr, io, ioe, uvd, uvc, rl;
    logic [4:1] pd;
    logic [3:2] pu;
    int         miscompares = 0, comparisons = 0, n, ext;
    int         offs[4] = '{'h106, 'h143, 'h144, 'h145};
    int         msk[4] = '{'hF0, 'h1B, 'hFF, 'h1F};
    int         shadow[4] = '{'h80, 0, 0, 0};
    int         exts[4] = '{0, 100, 500, 2500};

    always #10 clk = ~clk;

    iacr_host_model iacr_host_model_inst (.clk(clk), .reg_wr(wr), .reg_addr(addr),
        .reg_wdata(wd), .reg_rdata(rdata));

    iacr_config_regs #(.TIMEOUT_CYC(50)) iacr_config_regs_inst (.clk(clk), .rst(rst),
        .reg_wr(wr), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdata),
        .four_wire_sel(fw), .pin_takeover(pt), .two_wire_high_speed_en(hs),
        .two_wire_fast_plus_en(fp), .interface_supply_sel(isup), .input_supply_sel(gsup),
        .serial_clk_pin(scl), .two_wire_reset(twr), .irq_request(irq),
        .interrupt_out_o(io), .interrupt_out_oe(ioe), .io_lockout_disable(uvd),
        .io_lockout_cmp_en(uvc), .rail_transition(tr), .rail_good_raw(gr), .rail_good(good),
        .rail_oc_hit(hit), .rail_oc_event(oce), .input_pin_zero(pz),
        .pin_zero_is_input(pzi), .otp_reload_req(rl), .bidir_two_is_od(od2),
        .bidir_three_is_od(od3), .pull_down_en(pd), .pull_up_en(pu));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wait_n(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic count_resets(input int k);
        n = 0;
        repeat (k)
        begin
            wait_n(1);
            n += twr;
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        #(20 * 40000);
        miscompares++;
        wrap_up();
    end

    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 6; k++)
            for (int i = 0; i < 4; i++)
            begin
                iacr_host_model_inst.rd(offs[i][8:0], d);
                chk("register", shadow[i], d);
                lf = lfsr(lf);
                iacr_host_model_inst.wr(offs[i][8:0], lf);
                shadow[i] = lf & msk[i];
            end
        iacr_host_model_inst.wr(9'h107, 8'hFF);
        iacr_host_model_inst.rd(9'h107, d);
        chk("unmapped", 0, d);
        chk("supplies", {shadow[0][4], shadow[1][3]}, {isup, gsup});
        iacr_host_model_inst.wr(9'h106, 8'h60);
        wait_n(1);
        chk("four_wire", 3'b110, {fw, pt, hs});
        iacr_host_model_inst.wr(9'h106, 8'hE0);
        wait_n(1);
        chk("two_wire", 4'b0011, {fw, pt, hs, fp});
        for (int c = 0; c < 4; c++)
            for (int r = 0; r < 2; r++)
            begin
                iacr_host_model_inst.wr(9'h143, c[7:0]);
                irq <= r[0];
                wait_n(2);
                chk("irq_oe", c[1] ? !(r[0] ^ !c[0]) : 1, ioe);
                chk("irq_out", r[0] ^ !c[0], io);
            end
        iacr_host_model_inst.wr(9'h144, 8'h80);
        wait_n(1);
        chk("lockout", 2'b10, {uvd, uvc});
        for (int o = 0; o < 4; o++)
        begin
            od2 <= o[0];
            od3 <= o[1];
            iacr_host_model_inst.wr(9'h145, 8'h1E);
            wait_n(1);
            chk("pulls", {1'b1, !o[1], !o[0], 1'b1, o[1], o[0]}, {pd, pu});
        end
        iacr_host_model_inst.wr(9'h144, 8'h60);
        gr <= 2'b11;
        wait_n(3);
        tr <= 2'b11;
        gr <= 2'b00;
        wait_n(4);
        chk("good_hold", 2'b11, good);
        tr <= 2'b00;
        wait_n(4);
        chk("good_free", 2'b00, good);
        hit <= 2'b11;
        for (int r = 0; r < 2; r++)
            for (int m = 0; m < 4; m++)
            begin
                iacr_host_model_inst.wr(9'h144, 8'(m << (1 + 2 * r)));
                tr[r] <= 1'b1;
                wait_n(5);
                chk("oc_during", m == 0, oce[r]);
                @(posedge clk);
                tr[r] <= 1'b0;
                #1;
                n = 0;
                ext = exts[m];
                while (oce[r] !== 1'b1 && n < 3000)
                begin
                    wait_n(1);
                    n++;
                end
                chk("oc_extra", 1, n >= ext && n <= ext + 5);
            end
        hit <= 2'b00;
        iacr_host_model_inst.wr(9'h143, 8'h10);
        scl <= 1'b0;
        count_resets(70);
        chk("timeout_on", 1, n);
        scl <= 1'b1;
        wait_n(6);
        chk("timeout_end", 0, twr);
        iacr_host_model_inst.wr(9'h143, 8'h00);
        scl <= 1'b0;
        count_resets(70);
        chk("timeout_off", 0, n);
        scl <= 1'b1;
        for (int e = 1; e >= 0; e--)
        begin
            iacr_host_model_inst.wr(9'h144, e[7:0]);
            pzi <= 1'b1;
            pz <= 1'b0;
            wait_n(6);
            pz <= 1'b1;
            n = 0;
            for (int k = 0; k < 12; k++)
            begin
                wait_n(1);
                n += rl;
            end
            chk("reload", e, n);
        end
        wrap_up();
    end
endmodule // test_interface_app_config_regs
`default_nettype wire
